// >>> logic/ntw_pkg.sv
// Purpose: constants shared by the downstream window translation block
// Assumes: 32-bit control and status words, 4 KB translation granularity
// Notes: setup registers 2 and 3 are loaded over the serial-load port only
// Function
// [R1] registers answer memory and I/O accesses from primary and secondary ports
// [R2] window-2 hits take translated base bits 31:12 under the window-2 size mask
// [R3] window-3 hits take translated base bits 31:12 under the window-3 size mask
// [R4] setup bit 0 always reads 0, memory space requested
// [R5] setup bits 2:1 report 00 for 32-bit, 01 for 64-bit, reset 00
// [R6] setup bit 3 marks prefetchable when 1, resets non-prefetchable
// [R7] set size bits 30:12 make base bits writable, clear bits read-only
// [R8] setup bit 31 enables the window base register, resets disabled
// [R9] upper setup bits 30:0 choose per-bit writability of upper base register
// [R10] upper setup bit 31 enables the 64-bit window-3 base, resets 0
// [R11] address bits below the size boundary pass through, those above are replaced
package ntw_pkg;
  localparam logic [11:0] OFF_XBASE2 = 12'h008;
  localparam logic [11:0] OFF_SETUP2 = 12'h00c;
  localparam logic [11:0] OFF_XBASE3 = 12'h010;
  localparam logic [11:0] OFF_SETUP3 = 12'h014;
  localparam logic [11:0] OFF_UPPER3 = 12'h018;
  // loadable bits of a lower setup word: enable, size, prefetch, address type low bit
  // bit 2 stays 0 so the type field can only report 00 or 01
  localparam logic [31:0] SETUP_WR_MASK = 32'hffff_f00a;
  localparam logic [31:0] SETUP_RESET = 32'h0000_0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam int BIT_ENABLE = 31;
  localparam int BIT_PREF = 3;
  localparam int BIT_TYPE = 0;
  localparam int PAGE_LSB = 12;
  localparam int PAGE_W = 20;
  localparam logic [1:0] ATYPE_64 = 2'h1;
  localparam logic [1:0] BAR_SEL_W2 = 2'h0;
  localparam logic [1:0] BAR_SEL_W3 = 2'h1;
  localparam logic [1:0] BAR_SEL_W3HI = 2'h2;
endpackage

// >>> logic/ntw_win_xlate.sv
// Purpose: hit test and address substitution for one downstream window
// Assumes: size bits are contiguous from the top, as a base register size mask
// Notes: purely combinational; the top registers its hit and address outputs
`timescale 1ns/1ps
`default_nettype none
module ntw_win_xlate (
  input wire logic [63:0] addrIn,
  input wire logic [31:0] setup,
  input wire logic [31:0] upperSetup,
  input wire logic [19:0] barLo,
  input wire logic [31:0] barHi,
  input wire logic [19:0] xbase,
  output logic hit,
  output logic [63:0] addrOut
);
  logic [19:0] pageMask;
  logic [31:0] hiMask;
  logic is64;
  logic loMatch;
  logic hiMatch;

  // base bit 31 always compares; lower size bits open the rest
  assign pageMask = {1'b1, setup[30:ntw_pkg::PAGE_LSB]}; // R7
  assign hiMask = {1'b1, upperSetup[30:0]}; // R9
  assign is64 = (setup[2:1] == ntw_pkg::ATYPE_64) && upperSetup[ntw_pkg::BIT_ENABLE]; // R10
  assign loMatch = ((addrIn[31:ntw_pkg::PAGE_LSB] ^ barLo) & pageMask) == '0;
  // a 32-bit window only decodes addresses under 4 GB
  assign hiMatch = is64 ? (((addrIn[63:32] ^ barHi) & hiMask) == '0) : (addrIn[63:32] == '0);
  assign hit = setup[ntw_pkg::BIT_ENABLE] && loMatch && hiMatch; // R8

  // offset inside the window passes, page bits above come from the base
  assign addrOut = {32'h0000_0000, (xbase & pageMask) | (addrIn[31:ntw_pkg::PAGE_LSB] & ~pageMask),
    addrIn[ntw_pkg::PAGE_LSB-1:0]}; // R11
endmodule
`default_nettype wire

// >>> logic/ntw_downstream_xlate.sv
// Purpose: downstream memory 2/3 window registers and address translation
// Assumes: hosts hold a request until acknowledged and drop it the cycle after
// Notes: the primary port wins when both ports ask in the same cycle
`timescale 1ns/1ps
`default_nettype none
module ntw_downstream_xlate (
  input wire logic core_clk,
  input wire logic rst,
  // csr access, index 0 primary port, index 1 secondary port
  input wire logic [1:0] hostReq,
  input wire logic [1:0] hostWr,
  input wire logic [1:0][11:0] hostAddr,
  input wire logic [1:0][31:0] hostWdata,
  output logic [1:0] hostAck,
  output logic [1:0][31:0] hostRdata,
  // serial-load of the read-only setup words
  input wire logic setupLoad,
  input wire logic setupSel,
  input wire logic [31:0] setupData,
  // base address register writes from configuration space
  input wire logic barWr,
  input wire logic [1:0] barSel,
  input wire logic [31:0] barData,
  // downstream memory request address
  input wire logic dsReq,
  input wire logic [63:0] dsAddr,
  output logic dsValid,
  output logic [63:0] dsAddrOut,
  output logic dsHit2,
  output logic dsHit3
);
  typedef struct packed {
    logic [19:0] xbase2;
    logic [19:0] xbase3;
    logic [31:0] setup2;
    logic [31:0] setup3;
    logic [31:0] upper3;
    logic [19:0] bar2;
    logic [19:0] bar3;
    logic [31:0] bar3Hi;
    logic [1:0] ack;
    logic [1:0][31:0] rdata;
    logic valid;
    logic [63:0] addr;
    logic hit2;
    logic hit3;
  } ntw_state_t;

  ntw_state_t st;
  ntw_state_t next_st;
  logic [1:0] winHit;
  logic [1:0][63:0] winAddr;
  logic [1:0][31:0] winSetup;
  logic [1:0][31:0] winUpper;
  logic [1:0][19:0] winBarLo;
  logic [1:0][31:0] winBarHi;
  logic [1:0][19:0] winXbase;
  logic [1:0] grant;
  logic [11:0] gAddr;
  logic [31:0] gWdata;
  logic gWr;
  logic [31:0] readWord;
  logic [19:0] mask2;
  logic [19:0] mask3;

  //////////////////////////////////////////////////////////////////////////////
  // window translation units
  assign winSetup[0] = st.setup2;
  assign winSetup[1] = st.setup3;
  assign winUpper[0] = ntw_pkg::WORD_ZERO; // window 2 has no upper half
  assign winUpper[1] = st.upper3;
  assign winBarLo[0] = st.bar2;
  assign winBarLo[1] = st.bar3;
  assign winBarHi[0] = ntw_pkg::WORD_ZERO;
  assign winBarHi[1] = st.bar3Hi;
  assign winXbase[0] = st.xbase2;
  assign winXbase[1] = st.xbase3;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gWin
      ntw_win_xlate uXlate (
        .addrIn(dsAddr),
        .setup(winSetup[gi]),
        .upperSetup(winUpper[gi]),
        .barLo(winBarLo[gi]),
        .barHi(winBarHi[gi]),
        .xbase(winXbase[gi]),
        .hit(winHit[gi]),
        .addrOut(winAddr[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // port arbitration; an acked port is not served in the cycle its ack is showing
  assign grant[0] = hostReq[0] && !st.ack[0];
  assign grant[1] = hostReq[1] && !st.ack[1] && !grant[0];
  assign gAddr = grant[0] ? hostAddr[0] : hostAddr[1];
  assign gWdata = grant[0] ? hostWdata[0] : hostWdata[1];
  assign gWr = grant[0] ? hostWr[0] : hostWr[1];
  assign mask2 = {1'b1, st.setup2[30:ntw_pkg::PAGE_LSB]};
  assign mask3 = {1'b1, st.setup3[30:ntw_pkg::PAGE_LSB]};

  // read decode; memory and i/o accesses land on the same map
  always_comb begin
    readWord = ntw_pkg::WORD_ZERO;
    case (gAddr)
      ntw_pkg::OFF_XBASE2: readWord = {st.xbase2, 12'h000};
      ntw_pkg::OFF_SETUP2: readWord = st.setup2; // R4
      ntw_pkg::OFF_XBASE3: readWord = {st.xbase3, 12'h000};
      ntw_pkg::OFF_SETUP3: readWord = st.setup3;
      ntw_pkg::OFF_UPPER3: readWord = st.upper3;
      default: readWord = ntw_pkg::WORD_ZERO;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_st = st;
    next_st.ack = grant; // R1
    next_st.rdata[0] = grant[0] ? readWord : st.rdata[0];
    next_st.rdata[1] = grant[1] ? readWord : st.rdata[1];
    if ((|grant) && gWr) begin
      case (gAddr)
        ntw_pkg::OFF_XBASE2: next_st.xbase2 = gWdata[31:ntw_pkg::PAGE_LSB];
        ntw_pkg::OFF_XBASE3: next_st.xbase3 = gWdata[31:ntw_pkg::PAGE_LSB];
        ntw_pkg::OFF_UPPER3: next_st.upper3 = gWdata; // R9 R10
        default: next_st.upper3 = st.upper3; // setup words ignore host writes
      endcase
    end
    // forced bits stay 0 whatever the loader sends
    if (setupLoad && !setupSel) begin
      next_st.setup2 = setupData & ntw_pkg::SETUP_WR_MASK; // R4 R5 R6
    end
    if (setupLoad && setupSel) begin
      next_st.setup3 = setupData & ntw_pkg::SETUP_WR_MASK; // R4 R5 R6
    end
    // masked base writes; a disabled register keeps its value
    if (barWr && barSel == ntw_pkg::BAR_SEL_W2 && st.setup2[ntw_pkg::BIT_ENABLE]) begin
      next_st.bar2 = (st.bar2 & ~mask2) | (barData[31:ntw_pkg::PAGE_LSB] & mask2); // R7 R8
    end
    if (barWr && barSel == ntw_pkg::BAR_SEL_W3 && st.setup3[ntw_pkg::BIT_ENABLE]) begin
      next_st.bar3 = (st.bar3 & ~mask3) | (barData[31:ntw_pkg::PAGE_LSB] & mask3); // R7 R8
    end
    if (barWr && barSel == ntw_pkg::BAR_SEL_W3HI && st.upper3[ntw_pkg::BIT_ENABLE]) begin
      next_st.bar3Hi = (st.bar3Hi & ~{1'b1, st.upper3[30:0]})
        | (barData & {1'b1, st.upper3[30:0]}); // R9 R10
    end
    // window 2 wins if both windows overlap
    next_st.valid = dsReq;
    next_st.hit2 = dsReq && winHit[0];
    next_st.hit3 = dsReq && winHit[1] && !winHit[0];
    if (winHit[0]) begin
      next_st.addr = winAddr[0]; // R2 R11
    end else if (winHit[1]) begin
      next_st.addr = winAddr[1]; // R3 R11
    end else begin
      next_st.addr = dsAddr;
    end
  end

  // single state register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0; // R5 R6 R8 R10
    end else begin
      st <= next_st;
    end
  end

  assign hostAck = st.ack;
  assign hostRdata = st.rdata;
  assign dsValid = st.valid;
  assign dsAddrOut = st.addr;
  assign dsHit2 = st.hit2;
  assign dsHit3 = st.hit3;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence sWin2Req;
    dsReq && winHit[0];
  endsequence
  sequence sWin2Done;
    dsHit2 && dsAddrOut[31:12] == (($past(st.xbase2) & $past(mask2))
      | ($past(dsAddr[31:12]) & ~$past(mask2)));
  endsequence
  sequence sWin3Req;
    dsReq && winHit[1] && !winHit[0];
  endsequence
  sequence sWin3Done;
    dsHit3 && !dsHit2 && dsAddrOut[31:12] == (($past(st.xbase3) & $past(mask3))
      | ($past(dsAddr[31:12]) & ~$past(mask3)));
  endsequence

  AST_PRI_ACK: assert property (hostReq[0] && !hostAck[0] |=> hostAck[0] && !hostAck[1]) // R1
    else $error("primary request not acknowledged next cycle");
  AST_SEC_ACK: assert property (hostReq[1] && !hostAck[1] && !hostReq[0] |=> hostAck[1]) // R1
    else $error("secondary request not acknowledged next cycle");
  AST_WIN2_XLATE: assert property (sWin2Req |=> sWin2Done) // R2
    else $error("window 2 translation wrong");
  AST_WIN3_XLATE: assert property (sWin3Req |=> sWin3Done) // R3
    else $error("window 3 translation wrong");
  AST_TYPE_BIT: assert property (hostAck[0] && $past(hostAddr[0]) == ntw_pkg::OFF_SETUP2
    |-> hostRdata[0][0] == 1'b0) // R4
    else $error("setup type bit read as one");
  AST_ATYPE: assert property (setupLoad ##1 1'b1 |-> st.setup3[2] == 1'b0 && st.setup2[2] == 1'b0) // R5
    else $error("address type field holds an illegal code");
  AST_PREF: assert property (setupLoad && setupSel |=> st.setup3[3] == $past(setupData[3])) // R6
    else $error("prefetch bit not loaded");
  AST_BAR_RO: assert property (barWr |=> ((st.bar2 ^ $past(st.bar2)) & ~$past(mask2)) == '0) // R7
    else $error("read-only base bit changed");
  AST_DISABLED: assert property (!st.setup2[31] && dsReq |=> !dsHit2) // R8
    else $error("disabled window 2 hit");
  AST_UPPER_RO: assert property (barWr && !st.upper3[31] |=> st.bar3Hi == $past(st.bar3Hi)) // R9 R10
    else $error("disabled upper base changed");
  AST_PASS: assert property (dsReq |=> dsAddrOut[11:0] == $past(dsAddr[11:0]) && dsValid) // R11
    else $error("page offset not passed through");
endmodule
`default_nettype wire

// >>> test/ntw_host_model.sv
// Purpose: host on one register port of the window block
// Assumes: ack and read data are registered by the block
// Notes: released lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module ntw_host_model (
  input wire logic core_clk,
  input wire logic ack,
  input wire logic [31:0] rdata,
  output logic req,
  output logic wr,
  output logic [11:0] addr,
  output logic [31:0] wdata
);
  // idle host at time zero
  initial begin
    req = 1'b0;
    wr = 1'b0;
    addr = 12'h000;
    wdata = 32'h0000_0000;
  end
  ////////////////////////////////////////////////////////////////
  // one word, held until ack is sampled at an edge; bounded wait
  task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic ok);
    ok = 1'b0;
    q = 32'h0000_0000;
    @(posedge core_clk);
    #1;
    req = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(posedge core_clk);
      if (ack === 1'b1) begin
        ok = 1'b1;
        q = rdata;
      end
    end
    #1;
    req = 1'b0;
    wr = ~w;
    addr = ~a;
    wdata = ~d;
  endtask
endmodule
`default_nettype wire

// >>> test/test_ntb_downstream_window_xlate.sv
// Purpose: self-checking bench for the downstream window block
// Assumes: all inputs move 1 ns after the rising edge
// Notes: rows cover register access, hand tests cover translation
`timescale 1ns/1ps
`default_nettype none
module test_ntb_downstream_window_xlate;
  typedef struct packed {
    logic port;
    logic wr;
    logic [11:0] addr;
    logic [31:0] data;
    logic [31:0] exp;
  } ntw_row_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  wire logic [1:0] hostReq, hostWr;
  wire logic [1:0][11:0] hostAddr;
  wire logic [1:0][31:0] hostWdata;
  logic [1:0] hostAck;
  logic [1:0][31:0] hostRdata;
  logic setupLoad = 1'b0, setupSel = 1'b0, barWr = 1'b0, dsReq = 1'b0;
  logic [1:0] barSel = 2'h0;
  logic [31:0] setupData = 32'h0000_0000, barData = 32'h0000_0000;
  logic [63:0] dsAddr = 64'h0, dsAddrOut;
  logic dsValid, dsHit2, dsHit3;
  int bad_count = 0, comparisons = 0;
  ntw_row_t rows [11];
  ntw_host_model hostP (.core_clk(core_clk), .ack(hostAck[0]), .rdata(hostRdata[0]),
    .req(hostReq[0]), .wr(hostWr[0]), .addr(hostAddr[0]), .wdata(hostWdata[0]));
  ntw_host_model hostS (.core_clk(core_clk), .ack(hostAck[1]), .rdata(hostRdata[1]),
    .req(hostReq[1]), .wr(hostWr[1]), .addr(hostAddr[1]), .wdata(hostWdata[1]));
  ntw_downstream_xlate DUT (.core_clk(core_clk), .rst(rst), .hostReq(hostReq),
    .hostWr(hostWr), .hostAddr(hostAddr), .hostWdata(hostWdata), .hostAck(hostAck),
    .hostRdata(hostRdata), .setupLoad(setupLoad), .setupSel(setupSel),
    .setupData(setupData), .barWr(barWr), .barSel(barSel), .barData(barData),
    .dsReq(dsReq), .dsAddr(dsAddr), .dsValid(dsValid), .dsAddrOut(dsAddrOut),
    .dsHit2(dsHit2), .dsHit3(dsHit3));
  // 4 ns clock
  initial forever #2 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string name, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", name, e, g);
      bad_count++;
    end
  endtask
  // a host that never sees ack ends the run
  task automatic reg_io(input logic p, input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [31:0] e);
    logic [31:0] rq;
    logic rok;
    if (p) hostS.access(w, a, d, rq, rok);
    else hostP.access(w, a, d, rq, rok);
    if (rok !== 1'b1) begin
      $display("MISMATCH ack expected 1 seen %b", rok);
      bad_count++;
      summarize();
    end else if (!w) begin
      check("rdata", {32'h0, e}, {32'h0, rq});
    end
  endtask
  task automatic load(input logic s, input logic [31:0] d);
    @(posedge core_clk);
    #1;
    setupLoad = 1'b1;
    setupSel = s;
    setupData = d;
    @(posedge core_clk);
    #1;
    setupLoad = 1'b0;
    setupData = ~d;
  endtask
  task automatic barw(input logic [1:0] s, input logic [31:0] d);
    @(posedge core_clk);
    #1;
    barWr = 1'b1;
    barSel = s;
    barData = d;
    @(posedge core_clk);
    #1;
    barWr = 1'b0;
    barData = ~d;
  endtask
  // answer lands on the same edge that takes the request
  task automatic xlate(input logic [63:0] a, input logic [63:0] e, input logic h2,
      input logic h3);
    @(posedge core_clk);
    #1;
    dsReq = 1'b1;
    dsAddr = a;
    @(posedge core_clk);
    #1;
    dsReq = 1'b0;
    dsAddr = ~a;
    check("dsValid", 64'h1, {63'h0, dsValid});
    check("dsAddrOut", e, dsAddrOut);
    check("hits", {62'h0, h2, h3}, {62'h0, dsHit2, dsHit3});
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    rows = '{'{1'b0, 1'b1, 12'h008, 32'hffff_ffff, 32'h0},
      '{1'b0, 1'b0, 12'h008, 32'h0, 32'hffff_f000},
      '{1'b1, 1'b1, 12'h00c, 32'h0, 32'h0},
      '{1'b0, 1'b0, 12'h00c, 32'h0, 32'hfff0_000a},
      '{1'b0, 1'b1, 12'h010, 32'h8000_0fff, 32'h0},
      '{1'b1, 1'b0, 12'h010, 32'h0, 32'h8000_0000},
      '{1'b1, 1'b0, 12'h014, 32'h0, 32'hc000_0002},
      '{1'b0, 1'b1, 12'h018, 32'h8000_00ff, 32'h0},
      '{1'b1, 1'b0, 12'h018, 32'h0, 32'h8000_00ff},
      '{1'b0, 1'b1, 12'h01c, 32'h1234_5678, 32'h0},
      '{1'b1, 1'b0, 12'h01c, 32'h0, 32'h0}};
    repeat (4) @(posedge core_clk);
    #1 rst = 1'b0;
    load(1'b0, 32'hfff0_000b);
    load(1'b1, 32'hc000_0ff7);
    barw(2'h0, 32'habcd_e000);
    barw(2'h1, 32'h4000_0000);
    foreach (rows[i]) reg_io(rows[i].port, rows[i].wr, rows[i].addr, rows[i].data, rows[i].exp);
    barw(2'h2, 32'h0000_0012);
    xlate(64'h0000_0000_abc1_2345, 64'h0000_0000_fff1_2345, 1'b1, 1'b0);
    xlate(64'h0000_0000_abd0_0000, 64'h0000_0000_abd0_0000, 1'b0, 1'b0);
    xlate(64'h0000_0012_7000_0abc, 64'h0000_0000_b000_0abc, 1'b0, 1'b1);
    xlate(64'h0000_0013_7000_0abc, 64'h0000_0013_7000_0abc, 1'b0, 1'b0);
    // both ports at once, primary served first
    fork
      reg_io(1'b0, 1'b0, 12'h008, 32'h0, 32'hffff_f000);
      reg_io(1'b1, 1'b0, 12'h018, 32'h0, 32'h8000_00ff);
    join
    load(1'b0, 32'h7ff0_0000);
    xlate(64'h0000_0000_abc1_2345, 64'h0000_0000_abc1_2345, 1'b0, 1'b0);
    // second reset in mid-run clears every word
    @(posedge core_clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 rst = 1'b0;
    check("dsValid", 64'h0, {63'h0, dsValid});
    check("hits", 64'h0, {62'h0, dsHit2, dsHit3});
    for (int i = 0; i < 5; i++) reg_io(i[0], 1'b0, 12'h008 + 12'(4 * i), 32'h0, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
